// [rtl/dual_dac_serial_latch_ctrl.sv]
/*
  Serial front end and latch routing of a dual 8-bit converter.
  Assumes serial pins asynchronous to clk; link clock much slower than clk.
  Each shift clock level must last at least three clk cycles, so that the
  synchronised copy of the pin shows every edge.
*/
module dual_dac_serial_latch_ctrl
  import dac_ctrl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial link pins
  input wire logic chip_select_n,
  input wire logic shift_clk,
  input wire logic serial_data,
  // converter side
  output logic [CODE_BITS-1:0] code_a,
  output logic [CODE_BITS-1:0] code_b,
  output logic [CODE_BITS-1:0] buffer_code,
  output logic fast_settle_select,
  output logic power_down_select,
  output logic update_strobe,
  output logic word_dropped
);
  //////////////////////////////////////////////////////////////////////////
  // parameter checks
  if (DEPTH < 2 || (1 << $clog2(DEPTH)) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two of at least 2");
  end
  if (CODE_MSB - CODE_LSB + 1 != CODE_BITS) begin : g_code_check
    $error("code field width differs from CODE_BITS");
  end
  if (ADDR_HIGH_POS != WORD_BITS - 1) begin : g_addr_check
    $error("high address bit must be the first bit of a word");
  end
  if (int'(BIT_COUNT_FULL) != WORD_BITS) begin : g_count_check
    $error("bit counter end differs from word length");
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] cs_sync, sck_sync, din_sync;
  logic [1:0] next_cs_sync, next_sck_sync, next_din_sync;
  logic cs_n_q, sck_q, next_cs_n_q, next_sck_q;

  // only the second stage of each chain is read past this point
  always_comb begin
    next_cs_sync = {cs_sync[0], chip_select_n};
    next_sck_sync = {sck_sync[0], shift_clk};
    next_din_sync = {din_sync[0], serial_data};
    next_cs_n_q = cs_sync[1];
    next_sck_q = sck_sync[1];
  end

  // select starts idle high, so no false rise follows reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      din_sync <= 2'h0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cs_sync <= next_cs_sync;
      sck_sync <= next_sck_sync;
      din_sync <= next_din_sync;
      cs_n_q <= next_cs_n_q;
      sck_q <= next_sck_q;
    end
  end

  logic sck_fall, cs_rise, sel_active;
  // select counts as low if low at either end of the sample window, so a
  // last fall that lands in the same window as the select rise is kept
  assign sel_active = !(cs_n_q && cs_sync[1]);
  assign sck_fall = sck_q && !sck_sync[1];
  assign cs_rise = !cs_n_q && cs_sync[1];

  //////////////////////////////////////////////////////////////////////////
  // shift register
  logic [WORD_BITS-1:0] shift, next_shift;
  // counter stops at a full word; later falls are ignored until select rises
  logic [4:0] bit_count, next_bit_count;
  logic word_done;
  logic [WORD_BITS-1:0] word_out;

  always_comb begin
    next_shift = shift;
    next_bit_count = bit_count;
    word_done = 1'b0;
    word_out = shift;
    if (sel_active && sck_fall && bit_count < BIT_COUNT_FULL) begin
      next_shift = {shift[WORD_BITS-2:0], din_sync[1]};
      next_bit_count = bit_count + 5'h01;
      if (next_bit_count == BIT_COUNT_FULL) begin
        word_done = 1'b1;
        word_out = next_shift;
      end
    end
    if (cs_rise) begin
      // short word: left-align received bits so fields keep their place;
      // a bit taken in this same cycle still counts toward the word
      if (next_bit_count != 5'h00 &&
          next_bit_count < BIT_COUNT_FULL) begin
        word_done = 1'b1;
        word_out = next_shift << (BIT_COUNT_FULL - next_bit_count);
      end
      next_bit_count = 5'h00;
      next_shift = '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift <= '0;
      bit_count <= 5'h00;
    end else begin
      shift <= next_shift;
      bit_count <= next_bit_count;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // word buffering
  logic fifo_in_ready, fifo_out_valid;
  logic [WORD_BITS-1:0] fifo_out_data;

  // decouples word capture from routing; drained every cycle
  word_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(word_done),
    .in_ready(fifo_in_ready),
    .in_data(word_out),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // latch routing
  logic [CODE_BITS-1:0] next_code_a, next_code_b, next_buffer_code;
  logic next_fast, next_pwr, next_update, next_dropped;
  logic [1:0] addr;
  logic [CODE_BITS-1:0] word_code;

  // speed and power follow every applied word, buffer-only included
  always_comb begin
    addr = {fifo_out_data[ADDR_HIGH_POS], fifo_out_data[ADDR_LOW_POS]};
    word_code = fifo_out_data[CODE_MSB:CODE_LSB];
    next_code_a = code_a;
    next_code_b = code_b;
    next_buffer_code = buffer_code;
    next_fast = fast_settle_select;
    next_pwr = power_down_select;
    next_update = 1'b0;
    next_dropped = word_done && !fifo_in_ready;
    if (fifo_out_valid && addr != ADDR_RESERVED) begin
      next_fast = fifo_out_data[FAST_POS];
      next_pwr = fifo_out_data[PWR_POS];
      next_update = 1'b1;
      unique case (addr)
        ADDR_B_AND_BUF: begin
          next_code_b = word_code;
          next_buffer_code = word_code;
        end
        ADDR_BUF_ONLY: begin
          next_buffer_code = word_code;
        end
        ADDR_A_AND_B: begin
          next_code_a = word_code;
          next_code_b = buffer_code;
        end
        default: begin
          // reserved code, already filtered above
          next_update = 1'b0;
        end
      endcase
    end
  end

  // codes are never cleared by power down, so they return on wake
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_a <= CODE_RESET;
      code_b <= CODE_RESET;
      buffer_code <= CODE_RESET;
      fast_settle_select <= 1'b0;
      power_down_select <= 1'b0;
      update_strobe <= 1'b0;
      word_dropped <= 1'b0;
    end else begin
      code_a <= next_code_a;
      code_b <= next_code_b;
      buffer_code <= next_buffer_code;
      fast_settle_select <= next_fast;
      power_down_select <= next_pwr;
      update_strobe <= next_update;
      word_dropped <= next_dropped;
    end
  end
endmodule

// [rtl/dac_ctrl_pkg.sv]
/*
  Package for the dual converter serial latch controller: word layout,
  latch address codes and reset values.
  Assumes nothing of its surroundings.
*/
package dac_ctrl_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 8;
  localparam int ADDR_HIGH_POS = 15;
  localparam int FAST_POS = 14;
  localparam int PWR_POS = 13;
  localparam int ADDR_LOW_POS = 12;
  localparam int CODE_MSB = 11;
  localparam int CODE_LSB = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [1:0] ADDR_B_AND_BUF = 2'h0;
  localparam logic [1:0] ADDR_BUF_ONLY = 2'h1;
  localparam logic [1:0] ADDR_A_AND_B = 2'h2;
  localparam logic [1:0] ADDR_RESERVED = 2'h3;
endpackage

// [rtl/word_fifo.sv]
/*
  Word FIFO in flip-flops with valid and ready on both sides.
  Assumes one clock and an active-high asynchronous reset.
*/
module word_fifo
  import dac_ctrl_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_param_check
    $error("word_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;

  always_comb begin
    in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid = wr_ptr != rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// [sim/dac_ctrl_sva.sv]
/*
  Port checker for the serial latch controller.
  Assumes a bind onto the top design module.
*/
module dac_ctrl_sva
  import dac_ctrl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic chip_select_n,
  input wire logic shift_clk,
  input wire logic serial_data,
  // converter side
  input wire logic [CODE_BITS-1:0] code_a,
  input wire logic [CODE_BITS-1:0] code_b,
  input wire logic [CODE_BITS-1:0] buffer_code,
  input wire logic fast_settle_select,
  input wire logic power_down_select,
  input wire logic update_strobe,
  input wire logic word_dropped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  strobe_pulse_a: assert property (update_strobe |=> !update_strobe)
    else $error("strobe longer than one cycle");
  a_hold_a: assert property (!update_strobe |-> $stable(code_a))
    else $error("code a moved without update");
  b_hold_a: assert property (!update_strobe |-> $stable(code_b))
    else $error("code b moved without update");
  buf_hold_a: assert property (!update_strobe |-> $stable(buffer_code))
    else $error("buffer moved without update");
  power_hold_a: assert property (!update_strobe |->
    $stable(power_down_select)) else $error("power bit moved alone");
  speed_hold_a: assert property (!update_strobe |->
    $stable(fast_settle_select)) else $error("speed bit moved alone");
  joint_update_a: assert property ($changed(code_a) |->
    code_b == $past(buffer_code)) else $error("b not taken from buffer");
  b_mirror_a: assert property ($changed(code_b) |->
    buffer_code == code_b) else $error("buffer not mirroring b");
  idle_quiet_a: assert property (chip_select_n [*8] |=>
    !update_strobe) else $error("update while link idle");
endmodule

bind dual_dac_serial_latch_ctrl dac_ctrl_sva #(.DEPTH(DEPTH)) sva_i (.*);

// [sim/host_model.sv]
/*
  Host model shifting words into the controller.
  Assumes send is called after reset has been released.
*/
module host_model (
  // clock
  input wire logic clk,
  // serial link
  output logic chip_select_n,
  output logic shift_clk,
  output logic serial_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_select_n = 1'b1;
    shift_clk = 1'b1;
    serial_data = 1'b0;
  end
  // top n bits of w, one per falling edge, 200 ns link period
  task automatic send(input logic [15:0] w, input int n);
    @(posedge clk);
    chip_select_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      serial_data <= w[i];
      repeat (4) @(posedge clk);
      shift_clk <= 1'b0;
      repeat (4) @(posedge clk);
      shift_clk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
    // released line shows no stale bit
    serial_data <= ~serial_data;
    repeat (12) @(posedge clk);
  endtask
endmodule

// [sim/tb.sv]
/*
  Self-checking bench for the serial latch controller.
  Assumes the host model and the bound port checker.
*/
module tb
  import dac_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_select_n, shift_clk, serial_data;
  logic [CODE_BITS-1:0] code_a, code_b, buffer_code;
  logic fast_settle_select, power_down_select, update_strobe, word_dropped;
  logic [7:0] ea = 8'h00, eb = 8'h00, ebuf = 8'h00, n_upd = 8'h00;
  logic [7:0] e_upd = 8'h00, n_drop = 8'h00;
  logic ef = 1'b0, ep = 1'b0;
  int n_errors = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  host_model host_model_i (.*);
  dual_dac_serial_latch_ctrl dual_dac_serial_latch_ctrl_i (.*);
  always @(posedge clk) begin
    if (update_strobe === 1'b1) n_upd++;
    if (word_dropped === 1'b1) n_drop++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic s, input logic p,
      input logic [7:0] c, input int n);
    if (a == ADDR_B_AND_BUF) begin
      eb = c;
      ebuf = c;
    end else if (a == ADDR_BUF_ONLY)
      ebuf = c;
    else if (a == ADDR_A_AND_B) begin
      ea = c;
      eb = ebuf;
    end
    if (a != ADDR_RESERVED) begin
      ef = s;
      ep = p;
      e_upd++;
    end
    host_model_i.send({a[1], s, p, a[0], c, 4'h0}, n);
    check(code_a, ea);
    check(code_b, eb);
    check(buffer_code, ebuf);
    check({7'h00, fast_settle_select}, {7'h00, ef});
    check({7'h00, power_down_select}, {7'h00, ep});
    check(n_upd, e_upd);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    wr(ADDR_BUF_ONLY, 1'b0, 1'b0, 8'h5A, 16);
    wr(ADDR_A_AND_B, 1'b0, 1'b0, 8'h3C, 16);
    wr(ADDR_B_AND_BUF, 1'b1, 1'b0, 8'hC3, 12);
    wr(ADDR_A_AND_B, 1'b1, 1'b0, 8'h81, 16);
    wr(ADDR_RESERVED, 1'b0, 1'b1, 8'hFF, 16);
    wr(ADDR_BUF_ONLY, 1'b1, 1'b1, 8'h42, 16);
    wr(ADDR_BUF_ONLY, 1'b1, 1'b0, 8'h42, 16);
    check(n_drop, 8'h00);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule
